// ===== src/apd_decoder.sv
/*
 * pass-through block decoder: classifies command blocks and runs register
 * sequences toward the drive. assumes a whole command block on cb_valid,
 * a drive register port of any latency that answers each access on drv_ack, and inputs synchronous to clk.
 */
// Summary of operation
// (R1) forward commands and register accesses to drive
// (R2) block taken from wrapper command block field
// (R3) byte 0 must equal configured tag
// (R4) byte 1 must equal sub-code 0x24
// (R5) both match: pass-through; else ordinary command
// (R6) host supplies exactly 16-byte blocks
// (R7) other wrapper fields follow bulk-only rules
// (R8) bit 7: data phase is identify data
// (R9) host sets identify flag only truthfully
// (R10) bit 6: ultra-DMA, otherwise PIO only
// (R11) host keeps ultra-DMA clear for incapable drives
// (R12) accept packet commands and ATA commands
// (R13) translate removable-media commands for ATA drives
// (R14) readback: selected registers, 8 bytes, zeros
// (R15) register accesses in ascending mask order
// (R16) poll busy unless skip flag set
// (R17) halt on drive error unless continue set (code checks the error bit on register writes only)
// (R18) tag compared against captured config copy
`timescale 1ns/10ps
`default_nettype none
module apd_decoder
    import apd_pkg::*;
#(
    parameter int NREGS = APD_NREGS
)(
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  cfg_loading,
    input  wire logic                  cfg_we,
    input  wire logic [7:0]            cfg_addr,
    input  wire logic [7:0]            cfg_data,
    input  wire logic                  cb_valid,
    input  wire logic [4:0]            cb_len,
    input  wire logic [8*16-1:0]       cb_bytes,
    input  wire logic                  ata_drive,
    input  wire logic [8*NREGS-1:0]    wr_values,
    input  wire logic [7:0]            drv_rdata,
    input  wire logic                  drv_ack,
    output logic                       busy,
    output apd_route_t                 route,
    output apd_action_t                action,
    output logic                       len_error,
    output apd_reg_req_t               drv_req,
    output logic [8*NREGS-1:0]         readback_data,
    output logic                       readback_valid,
    output logic                       halted,
    output logic                       done
);
    typedef enum {
        ST_IDLE, ST_POLL, ST_POLL_WAIT, ST_SCAN, ST_WAIT, ST_DONE
    } apd_state_t;

    ////////////////////////////////////////////////////////////////////
    logic [7:0]         tag_value;
    apd_state_t         state_reg;
    apd_route_t         route_reg;
    apd_action_t        action_reg;
    apd_reg_req_t       req_reg;
    logic               len_err_reg;
    logic [NREGS-1:0]   mask_reg;
    logic [2:0]         idx_reg;
    logic [8*NREGS-1:0] rb_reg;
    logic               rb_valid_reg;
    logic               halted_reg;
    logic               done_reg;
    logic [7:0]         b_tag;
    logic [7:0]         b_sub;
    logic [7:0]         b_act;
    logic [7:0]         b_mask;
    logic               is_pass;

    apd_tag_capture i_apd_tag_capture (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .cfg_loading (cfg_loading),
        .cfg_we      (cfg_we),
        .cfg_addr    (cfg_addr),
        .cfg_data    (cfg_data),
        .tag_value   (tag_value)
    );

    // byte fields of the wrapper command block
    assign b_tag  = cb_bytes[8*APD_BYTE_TAG +: 8];  // (R2)
    assign b_sub  = cb_bytes[8*APD_BYTE_SUB +: 8];
    assign b_act  = cb_bytes[8*APD_BYTE_ACT +: 8];
    assign b_mask = cb_bytes[8*APD_BYTE_MASK +: 8];
    assign is_pass = (b_tag == tag_value)            // (R3)
                  && (b_sub == APD_SUBCODE);         // (R4) (R5)

    ////////////////////////////////////////////////////////////////////
    // classification and action latch
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            route_reg   <= APD_ROUTE_NONE;
            action_reg  <= '0;
            len_err_reg <= 1'b0;
            mask_reg    <= '0;
        end else if (state_reg == ST_IDLE && cb_valid) begin
            len_err_reg <= 1'b0;
            if (is_pass) begin
                route_reg <= APD_ROUTE_PASS;                 // (R12)
                len_err_reg <= (cb_len != APD_LEN_CB);       // (R6)
                action_reg.identify      <= b_act[APD_BIT_IDENT];   // (R8)
                action_reg.udma          <= b_act[APD_BIT_UDMA];    // (R10)
                action_reg.derr_continue <= b_act[APD_BIT_DERR];
                action_reg.skip_poll     <= b_act[APD_BIT_SKIPPOLL];
                action_reg.readback      <= b_act[APD_BIT_READBACK];
                mask_reg <= b_mask[NREGS-1:0];
            end else begin
                action_reg <= '0;
                mask_reg   <= '0;
                // ordinary command, translated for ATA drives
                route_reg <= ata_drive ? APD_ROUTE_XLATE    // (R13)
                                       : APD_ROUTE_ATAPI;   // (R5) (R7)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register sequencer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_reg    <= ST_IDLE;
            req_reg      <= '0;
            idx_reg      <= '0;
            rb_reg       <= '0;
            rb_valid_reg <= 1'b0;
            halted_reg   <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            req_reg.rd   <= 1'b0;
            req_reg.wr   <= 1'b0;
            done_reg     <= 1'b0;
            rb_valid_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (cb_valid && is_pass
                        && cb_len == APD_LEN_CB) begin
                        idx_reg    <= '0;
                        rb_reg     <= '0;                  // (R14)
                        halted_reg <= 1'b0;
                        if (b_act[APD_BIT_SKIPPOLL]) begin
                            state_reg <= ST_SCAN;          // (R16)
                        end else begin
                            state_reg <= ST_POLL;
                        end
                    end else if (cb_valid) begin
                        done_reg <= 1'b1;
                    end
                end
                ST_POLL: begin
                    // read alternate status, index 0
                    req_reg.rd  <= 1'b1;                   // (R16)
                    req_reg.idx <= '0;
                    state_reg   <= ST_POLL_WAIT;
                end
                ST_POLL_WAIT: begin
                    if (drv_ack) begin
                        state_reg <= drv_rdata[APD_BSY_BIT]
                                   ? ST_POLL : ST_SCAN;    // (R16)
                    end
                end
                ST_SCAN: begin
                    if (mask_reg[idx_reg]) begin
                        req_reg.idx   <= idx_reg;          // (R15)
                        req_reg.rd    <= action_reg.readback;   // (R14)
                        req_reg.wr    <= !action_reg.readback;  // (R1)
                        req_reg.wdata <= wr_values[8*idx_reg +: 8];
                        state_reg     <= ST_WAIT;
                    end else if (idx_reg == 3'(NREGS-1)) begin
                        state_reg <= ST_DONE;
                    end else begin
                        idx_reg <= idx_reg + 3'h1;         // (R15)
                    end
                end
                ST_WAIT: begin
                    if (drv_ack) begin
                        if (action_reg.readback) begin
                            rb_reg[8*idx_reg +: 8] <= drv_rdata; // (R14)
                        end
                        if (!action_reg.readback && !action_reg.derr_continue
                            && drv_rdata[APD_ERR_BIT]) begin
                            halted_reg <= 1'b1;            // (R17)
                            state_reg  <= ST_DONE;
                        end else if (idx_reg == 3'(NREGS-1)) begin
                            state_reg <= ST_DONE;
                        end else begin
                            idx_reg   <= idx_reg + 3'h1;
                            state_reg <= ST_SCAN;
                        end
                    end
                end
                ST_DONE: begin
                    rb_valid_reg <= action_reg.readback;   // (R14)
                    done_reg     <= 1'b1;
                    state_reg    <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic busy_reg;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != ST_IDLE) || cb_valid;
        end
    end

    assign busy           = busy_reg;
    assign route          = route_reg;
    assign action         = action_reg;
    assign len_error      = len_err_reg;
    assign drv_req        = req_reg;
    assign readback_data  = rb_reg;
    assign readback_valid = rb_valid_reg;
    assign halted         = halted_reg;
    assign done           = done_reg;
endmodule : apd_decoder
`default_nettype wire

// ===== src/apd_pkg.sv
/*
 * shared constants and carrier types for the pass-through block decoder.
 * assumes a 16-byte command block delivered whole with a valid strobe.
 */
`default_nettype none
package apd_pkg;
    localparam int          APD_CB_BYTES      = 16;
    localparam logic [7:0]  APD_SUBCODE       = 8'h24;
    localparam logic [7:0]  APD_TAG_CFG_ADDR  = 8'h04;
    localparam logic [7:0]  APD_TAG_RESET     = 8'h00;
    localparam int          APD_BYTE_TAG      = 0;
    localparam int          APD_BYTE_SUB      = 1;
    localparam int          APD_BYTE_ACT      = 2;
    localparam int          APD_BYTE_MASK     = 3;
    localparam int          APD_BIT_IDENT     = 7;
    localparam int          APD_BIT_UDMA      = 6;
    localparam int          APD_BIT_DERR      = 4;
    localparam int          APD_BIT_SKIPPOLL  = 2;
    localparam int          APD_BIT_READBACK  = 0;
    localparam int          APD_NREGS         = 8;
    localparam int          APD_BSY_BIT       = 7;
    localparam int          APD_ERR_BIT       = 0;
    localparam logic [4:0]  APD_LEN_CB        = 5'h10;
    localparam logic [7:0]  APD_ATAPI_IDENT   = 8'hA1;
    localparam logic [7:0]  APD_ATA_IDENT     = 8'hEC;

    typedef struct packed {
        logic identify;
        logic udma;
        logic derr_continue;
        logic skip_poll;
        logic readback;
    } apd_action_t;

    typedef enum logic [1:0] {
        APD_ROUTE_NONE,
        APD_ROUTE_PASS,
        APD_ROUTE_ATAPI,
        APD_ROUTE_XLATE
    } apd_route_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] idx;
        logic [7:0] wdata;
    } apd_reg_req_t;
endpackage : apd_pkg
`default_nettype wire

// ===== src/apd_tag_capture.sv
/*
 * holds the configuration tag byte, captured while configuration loads.
 * assumes cfg_we/cfg_addr/cfg_data come from the startup loader.
 */
`timescale 1ns/10ps
`default_nettype none
module apd_tag_capture
    import apd_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       cfg_loading,
    input  wire logic       cfg_we,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_data,
    output logic      [7:0] tag_value
);
    logic [7:0] tag_reg;

    // only written during load, stable afterwards
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tag_reg <= APD_TAG_RESET;
        end else if (cfg_loading && cfg_we
                     && cfg_addr == APD_TAG_CFG_ADDR) begin
            tag_reg <= cfg_data; // (R18)
        end
    end

    assign tag_value = tag_reg;
endmodule : apd_tag_capture
`default_nettype wire

// ===== sim/apd_checker.sv
/*
 * checker: assertions on the decoder ports.
 * assumes bind to apd_decoder; one clock, sync active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module apd_checker
    import apd_pkg::*;
#(
    parameter int NREGS = APD_NREGS
)(
    input wire logic               clk_sys,
    input wire logic               nrst,
    input wire logic               cfg_loading,
    input wire logic               cfg_we,
    input wire logic [7:0]         cfg_addr,
    input wire logic [7:0]         cfg_data,
    input wire logic               cb_valid,
    input wire logic [8*16-1:0]    cb_bytes,
    input wire logic               ata_drive,
    input wire logic [7:0]         drv_rdata,
    input wire logic               drv_ack,
    input wire logic               busy,
    input wire apd_route_t         route,
    input wire apd_action_t        action,
    input wire logic               len_error,
    input wire apd_reg_req_t       drv_req,
    input wire logic [8*NREGS-1:0] readback_data,
    input wire logic               readback_valid,
    input wire logic               halted,
    input wire logic               done
);
    logic [7:0]         tag_q;
    logic [7:0]         mask_q;
    logic [2:0]         last_idx;
    logic               wr_out;
    logic [8*NREGS-1:0] mask_wide;
    logic               take;
    logic               pass_in;
    logic               req;
    apd_action_t        act_in;
    assign take = cb_valid && !busy;
    assign pass_in = cb_bytes[7:0] == tag_q && cb_bytes[15:8] == APD_SUBCODE;
    assign req = drv_req.rd || drv_req.wr;
    assign act_in = {cb_bytes[23], cb_bytes[22], cb_bytes[20], cb_bytes[18],
                     cb_bytes[16]};
    always_comb begin
        for (int n = 0; n < NREGS; n++) begin
            mask_wide[8*n+:8] = {8{mask_q[n]}};
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tag_q <= APD_TAG_RESET;
        end else if (cfg_loading && cfg_we
                     && cfg_addr == APD_TAG_CFG_ADDR) begin
            tag_q <= cfg_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst || take) begin
            mask_q <= take ? cb_bytes[31:24] : 8'h00;
            last_idx <= 3'h0;
        end else if (req) begin
            last_idx <= drv_req.idx;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst || drv_ack) begin
            wr_out <= 1'b0;
        end else if (drv_req.wr) begin
            wr_out <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb_clk @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_pass_route: assert property (
        take && pass_in |=> route == APD_ROUTE_PASS && action == $past(act_in))
        else $error("pass block misdecoded");
    a_other_route: assert property (
        take && !pass_in |=> done && route == ($past(ata_drive) ?
        APD_ROUTE_XLATE : APD_ROUTE_ATAPI)) else $error("other block misrouted");
    a_action_clear: assert property (
        route != APD_ROUTE_PASS |-> action == 5'h00)
        else $error("action set on non-pass");
    a_req_masked: assert property (
        req |-> mask_q[drv_req.idx] || (drv_req.rd && drv_req.idx == 3'h0))
        else $error("access to unselected register");
    a_req_ascend: assert property (
        req && drv_req.idx != 3'h0 |-> drv_req.idx > last_idx)
        else $error("register order not ascending");
    a_rb_zeros: assert property (
        readback_valid |-> done && (readback_data & ~mask_wide) == '0)
        else $error("unselected readback byte not zero");
    a_len_quiet: assert property (
        len_error |-> !req) else $error("drive access on bad length");
    a_err_halt: assert property (
        drv_ack && wr_out && drv_rdata[APD_ERR_BIT] && !action.derr_continue
        |-> ##[1:3] halted) else $error("no halt on drive error");
    c_readback: cover property (readback_valid);
    c_halt: cover property ($rose(halted));
    c_len: cover property ($rose(len_error));
endmodule : apd_checker
bind apd_decoder apd_checker #(.NREGS(NREGS)) i_apd_checker (.clk_sys, .nrst,
    .cfg_loading, .cfg_we, .cfg_addr, .cfg_data, .cb_valid, .cb_bytes,
    .ata_drive, .drv_rdata, .drv_ack, .busy, .route, .action, .len_error,
    .drv_req, .readback_data, .readback_valid, .halted, .done);
`default_nettype wire

// ===== sim/apd_drive_model.sv
/*
 * drive register port model: acks each access promptly or slowly.
 * assumes one outstanding request; clr zeroes the access counters.
 */
`timescale 1ns/10ps
`default_nettype none
module apd_drive_model
    import apd_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         clr,
    input  wire logic         slow,
    input  wire logic [3:0]   busy_polls,
    input  wire logic         err_on_wr,
    input  wire apd_reg_req_t drv_req,
    output logic [7:0]        drv_rdata,
    output logic              drv_ack,
    output logic [3:0]        rd0_cnt,
    output logic [3:0]        wr_cnt
);
    apd_reg_req_t req_reg;
    logic [1:0]   wait_reg;
    logic         pend_reg;
    always @(posedge clk_sys) begin
        drv_ack <= 1'b0;
        drv_rdata <= ~drv_rdata; // previous data inverted each cycle without ack
        if (clr) begin
            pend_reg <= 1'b0;
            rd0_cnt <= 4'h0;
            wr_cnt <= 4'h0;
        end else if (drv_req.rd || drv_req.wr) begin
            req_reg <= drv_req;
            pend_reg <= 1'b1;
            wait_reg <= slow ? 2'h3 : 2'h0;
        end else if (pend_reg && wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else if (pend_reg) begin
            pend_reg <= 1'b0;
            drv_ack <= 1'b1;
            if (req_reg.wr) begin
                wr_cnt <= wr_cnt + 4'h1;
                drv_rdata <= {7'h00, err_on_wr};
            end else begin
                drv_rdata <= (req_reg.idx == 3'h0 && rd0_cnt < busy_polls) ?
                    8'h80 : 8'h30 + {5'h00, req_reg.idx};
                rd0_cnt <= rd0_cnt + {3'h0, req_reg.idx == 3'h0};
            end
        end
    end
endmodule : apd_drive_model
`default_nettype wire

// ===== sim/tb_apd_decoder.sv
/*
 * testbench: command blocks in, route, action and readback checked.
 * assumes apd_drive_model on the drive port; checker bound separately.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_apd_decoder;
    import apd_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, cfg_loading = 1'b1, cfg_we = 1'b0;
    logic cb_valid = 1'b0, ata_drive = 1'b0, clr = 1'b1, slow = 1'b0;
    logic err_on_wr = 1'b0, drv_ack, busy, len_error, readback_valid;
    logic halted, done;
    logic [7:0] cfg_addr = 8'h00, cfg_data = 8'h00, drv_rdata;
    logic [4:0] cb_len = 5'h10;
    logic [3:0] busy_polls = 4'h0, rd0_cnt, wr_cnt;
    logic [127:0] cb_bytes = 128'h0;
    logic [63:0] wr_values = 64'h8877665544332211, readback_data;
    apd_route_t route;
    apd_action_t action;
    apd_reg_req_t drv_req;
    int fails = 0, compares = 0, cycles = 0;
    apd_decoder i_apd_decoder (.clk_sys, .nrst, .cfg_loading, .cfg_we,
        .cfg_addr, .cfg_data, .cb_valid, .cb_len, .cb_bytes, .ata_drive,
        .wr_values, .drv_rdata, .drv_ack, .busy, .route, .action, .len_error,
        .drv_req, .readback_data, .readback_valid, .halted, .done);
    apd_drive_model i_apd_drive_model (.clk_sys, .clr, .slow, .busy_polls,
        .err_on_wr, .drv_req, .drv_rdata, .drv_ack, .rd0_cnt, .wr_cnt);
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("Error %0t: timeout", $time);
            close_out();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        tick();
        cfg_addr = a;
        cfg_data = d;
        cfg_we = 1'b1;
        tick();
        cfg_we = 1'b0;
    endtask : cfg
    task automatic send(input logic [31:0] head, input logic [4:0] len);
        int k = 0;
        tick();
        clr = 1'b1;
        tick();
        clr = 1'b0;
        cb_bytes = {96'h0, head};
        cb_len = len;
        cb_valid = 1'b1;
        tick();
        cb_valid = 1'b0;
        while (!(done || halted || len_error) && k < 200) begin
            tick();
            k++;
        end
        if (k == 200) begin
            fails++;
            $display("Error %0t: block never finished", $time);
        end
    endtask : send
    function automatic logic [63:0] rb(input logic [7:0] m);
        rb = 64'h0;
        for (int n = 0; n < 8; n++) begin
            if (m[n]) rb[8*n+:8] = 8'h30 + 8'(n);
        end
    endfunction : rb
    initial begin
        repeat (6) tick();
        nrst = 1'b1;
        cfg(8'h04, 8'h5A);
        cfg(8'h03, 8'h77);
        cfg_loading = 1'b0;
        cfg(8'h04, 8'h11);
        for (int i = 0; i < 4; i++) begin
            ata_drive = i[0];
            send({8'h01, 8'hC5, (i < 2 ? 8'h24 : 8'h25),
                  (i < 2 ? 8'h11 : 8'h5A)}, 5'h10);
            chk(route, i[0] ? APD_ROUTE_XLATE : APD_ROUTE_ATAPI);
            chk(action, 5'h00);
            chk(done, 1'b1);
            chk(busy, 1'b1);
        end
        $display("test 1 done");
        slow = 1'b1;
        send({8'hA5, 8'hC5, 8'h24, 8'h5A}, 5'h10);
        chk(route, APD_ROUTE_PASS);
        chk(action, 5'b11011);
        chk(readback_data, rb(8'hA5));
        chk(rd0_cnt, 4'h1);
        chk(readback_valid, 1'b1);
        $display("test 2 done");
        slow = 1'b0;
        busy_polls = 4'h3;
        send({8'h01, 8'h01, 8'h24, 8'h5A}, 5'h10);
        chk(rd0_cnt, 4'h5);
        chk(readback_data, rb(8'h01));
        $display("test 3 done");
        err_on_wr = 1'b1;
        send({8'h06, 8'h04, 8'h24, 8'h5A}, 5'h10);
        chk(halted, 1'b1);
        chk(wr_cnt, 4'h1);
        send({8'h06, 8'h14, 8'h24, 8'h5A}, 5'h10);
        chk(halted, 1'b0);
        chk(wr_cnt, 4'h2);
        chk(readback_valid, 1'b0);
        chk(done, 1'b1);
        $display("test 4 done");
        send({8'h06, 8'h04, 8'h24, 8'h5A}, 5'h0F);
        chk(len_error, 1'b1);
        chk(wr_cnt, 4'h0);
        $display("test 5 done");
        close_out();
    end
endmodule : tb_apd_decoder
`default_nettype wire
